/* File: rtl/swb_pkg.sv */
// Constants and types shared by the serial to single-wire mode engine.
// Assumes a 200 MHz system clock and a host UART at the 9600 bit/s rate.
package swb_pkg;

  // Timing
  localparam int CLK_HZ   = 200_000_000;
  localparam int BAUD_HZ  = 9600;
  localparam int OVS      = 16;
  localparam int TICK_DIV = CLK_HZ / (BAUD_HZ * OVS);
  localparam int TICK_W   = 11;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_DIV - 1);
  localparam logic [3:0] OVS_LAST = 4'(OVS - 1);
  localparam logic [3:0] OVS_MID  = 4'(OVS / 2 - 1);

  // Reserved codes and fixed response parts
  localparam logic [7:0] CODE_DATA = 8'he1;
  localparam logic [7:0] CODE_CMD  = 8'he3;
  localparam logic [7:0] CODE_TERM = 8'hf1;
  localparam logic [7:0] PRES_BYTE = 8'h01;
  localparam logic [1:0] RSP_RST_TOP = 2'h3;
  localparam logic [1:0] PAD_ZERO    = 2'h0;
  localparam logic [2:0] REV_DEF     = 3'h3;

  // Command byte fields
  localparam int B_TYPE  = 7;
  localparam int B_LEGAL = 0;
  localparam int B_FLAG  = 4;
  localparam int B_ARM   = 1;
  localparam logic [1:0] FN_BIT    = 2'h0;
  localparam logic [1:0] FN_SEARCH = 2'h1;
  localparam logic [1:0] FN_RESET  = 2'h2;
  localparam logic [1:0] FN_PULSE  = 2'h3;
  localparam logic [1:0] SPD_PULSE = 2'h3;
  localparam logic [2:0] CFG_READ  = 3'h0;

  // Register port: status {pres, arm, accel, speed[1:0], cal_done, mode[1:0]}
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_CTRL   = 2'h1;
  localparam int CT_PEN = 0;
  localparam int CT_MR  = 1;
  localparam logic CT_PEN_RST = 1'h1;

  typedef enum logic [1:0] {MD_CMD, MD_DATA, MD_CHECK} swb_mode_t;
  typedef enum logic [1:0] {PH_CAL, PH_IDLE, PH_BUS, PH_SEND} swb_ph_t;
  typedef enum logic [1:0] {OP_RESET, OP_BIT, OP_PULSE, OP_DATA} swb_op_t;

endpackage

/* File: rtl/swb_ser_if.sv */
// Serial byte carrier between the mode engine and its receiver and transmitter.
// All signals are synchronous to the single system clock.
`timescale 1ns/1ps
interface swb_ser_if;
  logic       tick;
  logic [7:0] rx_data;
  logic       rx_valid;
  logic       rx_break;
  logic [7:0] tx_data;
  logic       tx_valid;
  logic       tx_busy;
  modport eng (output tick, tx_data, tx_valid, input rx_data, rx_valid, rx_break, tx_busy);
  modport rx  (input tick, output rx_data, rx_valid, rx_break);
  modport tx  (input tick, tx_data, tx_valid, output tx_busy);
endinterface

/* File: rtl/swb_ser_rx.sv */
// Host serial receiver: 8 data bits, no parity, 16x oversampled.
// Assumes the line input is already synchronous to clk_i.
`timescale 1ns/1ps
module swb_ser_rx (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // Serial line and carrier
  input  wire logic line_i,
  swb_ser_if.rx     sif
);
  typedef enum logic [2:0] {R_IDLE, R_START, R_BITS, R_STOP, R_BRK} swb_rxs_t;
  swb_rxs_t   st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic       vld_q, vld_d, brk_q, brk_d;

  always_comb begin
    st_d = st_q; cnt_d = cnt_q; bit_d = bit_q; sh_d = sh_q;
    vld_d = 1'b0; brk_d = 1'b0;
    unique case (st_q)
      R_IDLE: if (!line_i) begin st_d = R_START; cnt_d = '0; end
      R_START: if (sif.tick) begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == swb_pkg::OVS_MID) begin
          cnt_d = '0; bit_d = '0;
          st_d  = line_i ? R_IDLE : R_BITS;
        end
      end
      R_BITS: if (sif.tick) begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == swb_pkg::OVS_LAST) begin
          sh_d  = {line_i, sh_q[7:1]};
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'h7) st_d = R_STOP;
        end
      end
      // Only the first stop bit is checked; a second one looks like idle [R01]
      R_STOP: if (sif.tick && cnt_q == swb_pkg::OVS_LAST) begin
        vld_d = line_i;
        brk_d = !line_i;
        st_d  = line_i ? R_IDLE : R_BRK;
      end else if (sif.tick) cnt_d = cnt_q + 4'h1;
      // Hold off until the line returns high, so a long break resets once
      R_BRK: if (line_i) st_d = R_IDLE;
      default: st_d = R_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= R_IDLE; cnt_q <= '0; bit_q <= '0; sh_q <= '0;
      vld_q <= 1'b0; brk_q <= 1'b0;
    end else begin
      st_q <= st_d; cnt_q <= cnt_d; bit_q <= bit_d; sh_q <= sh_d;
      vld_q <= vld_d; brk_q <= brk_d;
    end
  end

  assign sif.rx_data  = sh_q;
  assign sif.rx_valid = vld_q;
  assign sif.rx_break = brk_q;
endmodule // swb_ser_rx

/* File: rtl/swb_ser_tx.sv */
// Host serial transmitter: start bit, 8 data bits, exactly one stop bit.
// Assumes tx_valid is a one-cycle pulse given only while tx_busy is low.
`timescale 1ns/1ps
module swb_ser_tx (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // Carrier and serial line
  swb_ser_if.tx     sif,
  output logic      line_o
);
  logic       busy_q, busy_d, line_q, line_d;
  logic [8:0] sh_q, sh_d;
  logic [3:0] n_q, n_d, cnt_q, cnt_d;

  always_comb begin
    busy_d = busy_q; line_d = line_q; sh_d = sh_q; n_d = n_q; cnt_d = cnt_q;
    if (!busy_q && sif.tx_valid) begin
      busy_d = 1'b1; line_d = 1'b0; cnt_d = '0;
      sh_d = {1'b1, sif.tx_data};
      n_d  = 4'h9;
    end else if (busy_q && sif.tick) begin
      cnt_d = cnt_q + 4'h1;
      if (cnt_q == swb_pkg::OVS_LAST) begin
        if (n_q == 4'h0) busy_d = 1'b0;
        else begin
          line_d = sh_q[0];
          sh_d   = {1'b1, sh_q[8:1]};
          n_d    = n_q - 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_q <= 1'b0; line_q <= 1'b1; sh_q <= '1; n_q <= '0; cnt_q <= '0;
    end else begin
      busy_q <= busy_d; line_q <= line_d; sh_q <= sh_d; n_q <= n_d; cnt_q <= cnt_d;
    end
  end

  assign sif.tx_busy = busy_q;
  assign line_o      = line_q; // Single stop bit only [R01]
endmodule // swb_ser_tx

/* File: rtl/swb_mode_engine.sv */
// Command and mode engine of a serial to single-wire bridge.
// Assumes an external slot engine that runs bus ops and reports results.
//
// Functional notes
// [R01] Receive 8N1 or 8N2, send one stop
// [R02] Power-up: master reset, then Command Mode
// [R03] First byte only calibrates, silent
// [R04] Stop bit low forces master reset
// [R05] Host forces reset by break or parity; code has no parity check, resets on break or the CTRL MR bit
// [R06] Host recalibrates after software master reset
// [R07] Data Mode bytes become slots, echo result
// [R08] Search flag makes twelve-bit sequences
// [R09] Armed pullup follows each bus byte
// [R10] Data Mode switch code enters Check Mode
// [R11] Repeated code written once, back to Data
// [R12] Other byte executed as command, Command Mode
// [R13] Host doubles switch code sent as data
// [R14] Command Mode presence pulse reports xxxxxx01
// [R15] Data Mode never reports bus arrivals
// [R16] Command MSB picks communication or configuration
// [R17] Reserved codes: data, command, pulse terminate
// [R18] Legal commands answer except reserved, search
// [R19] Terminate code ends pulse, sends its answer
// [R20] Host never repeats command code in Command
// [R21] Speed bits latch at once, always; code latches them on search, reset and bit commands only
// [R22] Reset answer: reaction, revision, programming voltage
// [R23] Bytes handled in order after bus completes
`timescale 1ns/1ps
module swb_mode_engine #(
  parameter logic [2:0] REV      = swb_pkg::REV_DEF, // Arbitrary revision value
  parameter int         TICK_DIV = swb_pkg::TICK_DIV // Clocks per oversampling tick
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // Host serial line
  input  wire logic        ser_rx_i,
  output logic             ser_tx_o,
  // Register port
  input  wire logic [1:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic [7:0]       reg_rdata_o,
  // Slot engine requests
  output logic             bus_req_o,
  output swb_pkg::swb_op_t bus_op_o,
  output logic [7:0]       bus_data_o,
  output logic [1:0]       bus_speed_o,
  output logic             bus_accel_o,
  output logic             bus_spu_arm_o,
  output logic             bus_abort_o,
  // Slot engine results
  input  wire logic        bus_done_i,
  input  wire logic [7:0]  bus_result_i,
  input  wire logic        bus_presence_i,
  input  wire logic        vpp_i
);

  swb_ser_if sif ();

  swb_ser_rx u_rx (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .line_i   (ser_rx_i),
    .sif      (sif.rx)
  );

  swb_ser_tx u_tx (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .sif      (sif.tx),
    .line_o   (ser_tx_o)
  );

  // Oversampling tick divider; a bench may shorten the tick to keep runs brief
  localparam int            TW       = swb_pkg::TICK_W;
  localparam logic [TW-1:0] TICK_END = TW'(TICK_DIV - 1);
  logic [swb_pkg::TICK_W-1:0] div_q, div_d;
  logic                       tick_q, tick_d;

  always_comb begin
    tick_d = (div_q == TICK_END);
    div_d  = tick_d ? '0 : div_q + 1'b1;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  assign sif.tick = tick_q;

  // Register port state
  logic       pen_q, pen_d;
  logic       smr_q, smr_d;
  logic [7:0] rd_q, rd_d;

  // Engine state
  swb_pkg::swb_mode_t mode_q, mode_d;
  swb_pkg::swb_ph_t   ph_q, ph_d;
  swb_pkg::swb_op_t   op_q, op_d;
  logic [1:0] spd_q, spd_d;
  logic       acc_q, acc_d;
  logic       arm_q, arm_d;
  logic [7:0] hold_q, hold_d;
  logic       hold_v_q, hold_v_d;
  logic       req_q, req_d;
  logic [7:0] dat_q, dat_d;
  logic       abort_q, abort_d;
  logic [7:0] rsp_q, rsp_d;
  logic       txv_q, txv_d;
  logic       pres_q, pres_d;
  logic [2:0] cfg_q [8];
  logic [2:0] cfg_d [8];

  logic       mr;
  logic       take;
  logic       cmd_go;
  logic       data_go;
  logic       pres_clr;
  logic [7:0] status;

  // Software master reset behaves like a line break
  assign mr = sif.rx_break | smr_q; // [R04]

  assign status = {pres_q, arm_q, acc_q, spd_q, ph_q != swb_pkg::PH_CAL, mode_q};

  always_comb begin
    pen_d = pen_q;
    smr_d = 1'b0;
    rd_d  = '0;
    if (reg_we_i && reg_addr_i == swb_pkg::REG_CTRL) begin
      pen_d = reg_wdata_i[swb_pkg::CT_PEN];
      smr_d = reg_wdata_i[swb_pkg::CT_MR];
    end
    if (reg_re_i) begin
      if (reg_addr_i == swb_pkg::REG_STATUS) rd_d = status;
      else if (reg_addr_i == swb_pkg::REG_CTRL) rd_d = {7'h0, pen_q};
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pen_q <= swb_pkg::CT_PEN_RST;
      smr_q <= 1'b0;
      rd_q  <= '0;
    end else begin
      pen_q <= pen_d;
      smr_q <= smr_d;
      rd_q  <= rd_d;
    end
  end

  assign reg_rdata_o = rd_q;

  // Command and mode sequencing
  always_comb begin
    mode_d  = mode_q;
    ph_d    = ph_q;
    op_d    = op_q;
    spd_d   = spd_q;
    acc_d   = acc_q;
    arm_d   = arm_q;
    dat_d   = dat_q;
    rsp_d   = rsp_q;
    cfg_d   = cfg_q;
    req_d   = 1'b0;
    abort_d = 1'b0;
    txv_d   = 1'b0;
    take     = 1'b0;
    cmd_go   = 1'b0;
    data_go  = 1'b0;
    pres_clr = 1'b0;

    unique case (ph_q)
      swb_pkg::PH_CAL: if (hold_v_q) begin
        take = 1'b1; // [R03]
        ph_d = swb_pkg::PH_IDLE;
      end
      swb_pkg::PH_IDLE: if (hold_v_q) begin
        take = 1'b1;
        unique case (mode_q)
          swb_pkg::MD_DATA: begin
            if (hold_q == swb_pkg::CODE_CMD) mode_d = swb_pkg::MD_CHECK; // [R10]
            else data_go = 1'b1; // [R07]
          end
          swb_pkg::MD_CHECK: begin
            if (hold_q == swb_pkg::CODE_CMD) begin
              mode_d  = swb_pkg::MD_DATA; // [R11]
              data_go = 1'b1;
            end else begin
              mode_d = swb_pkg::MD_CMD; // [R12]
              cmd_go = 1'b1;
            end
          end
          default: cmd_go = 1'b1;
        endcase
      end else if (pres_q) begin
        rsp_d    = swb_pkg::PRES_BYTE; // [R14]
        pres_clr = 1'b1;
        ph_d     = swb_pkg::PH_SEND;
      end
      swb_pkg::PH_BUS: begin
        if (bus_done_i) begin
          ph_d = swb_pkg::PH_SEND; // [R23]
          unique case (op_q)
            swb_pkg::OP_RESET: rsp_d = {swb_pkg::RSP_RST_TOP, vpp_i, REV, bus_result_i[1:0]}; // [R22]
            swb_pkg::OP_BIT:   rsp_d = {dat_q[7:2], {2{bus_result_i[0]}}};
            swb_pkg::OP_PULSE: rsp_d = {dat_q[7:2], swb_pkg::PAD_ZERO}; // [R19]
            default:           rsp_d = bus_result_i;
          endcase
        end else if (hold_v_q && hold_q == swb_pkg::CODE_TERM
                     && op_q == swb_pkg::OP_PULSE) begin
          take    = 1'b1;
          abort_d = 1'b1; // [R19]
        end
      end
      swb_pkg::PH_SEND: if (!sif.tx_busy && !txv_q) begin
        txv_d = 1'b1;
        ph_d  = swb_pkg::PH_IDLE;
      end
    endcase

    if (data_go) begin
      req_d = 1'b1;
      op_d  = swb_pkg::OP_DATA;
      dat_d = hold_q;
      ph_d  = swb_pkg::PH_BUS;
    end

    if (cmd_go) begin
      if (hold_q == swb_pkg::CODE_DATA) begin
        mode_d = swb_pkg::MD_DATA; // [R17]
      end else if (hold_q == swb_pkg::CODE_CMD || hold_q == swb_pkg::CODE_TERM) begin
        // Stray switch or terminate code is swallowed silently [R17]
      end else if (!hold_q[swb_pkg::B_LEGAL]) begin
        // Illegal command: no bus activity, no answer [R18]
      end else if (!hold_q[swb_pkg::B_TYPE]) begin
        ph_d = swb_pkg::PH_SEND; // [R16]
        if (hold_q[6:4] == swb_pkg::CFG_READ) begin
          rsp_d = {1'b0, hold_q[3:1], cfg_q[hold_q[3:1]], 1'b0};
        end else begin
          cfg_d[hold_q[6:4]] = hold_q[3:1];
          rsp_d = {hold_q[7:1], 1'b0};
        end
      end else begin
        unique case (hold_q[6:5])
          swb_pkg::FN_SEARCH: begin
            acc_d = hold_q[swb_pkg::B_FLAG]; // [R18]
            spd_d = hold_q[3:2]; // [R21]
          end
          swb_pkg::FN_RESET: begin
            spd_d = hold_q[3:2]; // [R21]
            op_d  = swb_pkg::OP_RESET;
          end
          swb_pkg::FN_BIT: begin
            spd_d = hold_q[3:2]; // [R21]
            op_d  = swb_pkg::OP_BIT;
          end
          default: begin
            if (hold_q[3:2] == swb_pkg::SPD_PULSE) begin
              arm_d = hold_q[swb_pkg::B_ARM];
              op_d  = swb_pkg::OP_PULSE;
            end
          end
        endcase
        if (hold_q[6:5] != swb_pkg::FN_SEARCH
            && !(hold_q[6:5] == swb_pkg::FN_PULSE && hold_q[3:2] != swb_pkg::SPD_PULSE)) begin
          req_d = 1'b1;
          dat_d = hold_q;
          ph_d  = swb_pkg::PH_BUS;
        end
      end
    end

    // Presence set wins over the clear from sending it
    pres_d = (pres_q & ~pres_clr)
           | (bus_presence_i & pen_q & mode_q == swb_pkg::MD_CMD & ph_q != swb_pkg::PH_CAL);
    if (mode_d == swb_pkg::MD_DATA) pres_d = 1'b0; // [R15]

    if (mr) begin
      mode_d = swb_pkg::MD_CMD; // [R04]
      ph_d   = swb_pkg::PH_CAL;
      spd_d  = '0;
      acc_d  = 1'b0;
      arm_d  = 1'b0;
      req_d  = 1'b0;
      pres_d = 1'b0;
    end
  end

  // New byte overwrites the holding slot; a taken byte leaves it
  always_comb begin
    hold_d   = sif.rx_valid ? sif.rx_data : hold_q;
    hold_v_d = (hold_v_q & ~take) | sif.rx_valid;
    if (mr) hold_v_d = 1'b0;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_q   <= swb_pkg::MD_CMD; // [R02]
      ph_q     <= swb_pkg::PH_CAL;
      op_q     <= swb_pkg::OP_RESET;
      spd_q    <= '0;
      acc_q    <= 1'b0;
      arm_q    <= 1'b0;
      hold_q   <= '0;
      hold_v_q <= 1'b0;
      req_q    <= 1'b0;
      dat_q    <= '0;
      abort_q  <= 1'b0;
      rsp_q    <= '0;
      txv_q    <= 1'b0;
      pres_q   <= 1'b0;
      cfg_q    <= '{default: '0};
    end else begin
      mode_q   <= mode_d;
      ph_q     <= ph_d;
      op_q     <= op_d;
      spd_q    <= spd_d;
      acc_q    <= acc_d;
      arm_q    <= arm_d;
      hold_q   <= hold_d;
      hold_v_q <= hold_v_d;
      req_q    <= req_d;
      dat_q    <= dat_d;
      abort_q  <= abort_d;
      rsp_q    <= rsp_d;
      txv_q    <= txv_d;
      pres_q   <= pres_d;
      cfg_q    <= cfg_d;
    end
  end

  assign sif.tx_data    = rsp_q;
  assign sif.tx_valid   = txv_q;
  assign bus_req_o      = req_q;
  assign bus_op_o       = op_q;
  assign bus_data_o     = dat_q;
  assign bus_speed_o    = spd_q;
  assign bus_accel_o    = acc_q; // Slot engine expands data to twelve bits [R08]
  assign bus_spu_arm_o  = arm_q; // Slot engine pulls up after each byte [R09]
  assign bus_abort_o    = abort_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  localparam logic [1:0] PRES_LSB = swb_pkg::PRES_BYTE[1:0];

  sequence s_pick;
    ph_q == swb_pkg::PH_IDLE && hold_v_q && !mr;
  endsequence

  sequence s_dup;
    s_pick ##0 mode_q == swb_pkg::MD_CHECK && hold_q == swb_pkg::CODE_CMD;
  endsequence

  a_mr_to_cal: assert property (sif.rx_break |=> ph_q == swb_pkg::PH_CAL // [R04]
    && mode_q == swb_pkg::MD_CMD && !hold_v_q)
    else $error("master reset did not return to calibration");

  a_cal_silent: assert property (ph_q == swb_pkg::PH_CAL && hold_v_q && !mr // [R03]
    |=> !req_q && ph_q == swb_pkg::PH_IDLE ##1 !txv_q)
    else $error("calibration byte caused activity");

  a_data_conv: assert property (s_pick ##0 mode_q == swb_pkg::MD_DATA // [R07]
    && hold_q != swb_pkg::CODE_CMD |=> req_q && op_q == swb_pkg::OP_DATA
    && dat_q == $past(hold_q))
    else $error("data byte not sent to bus");

  a_check_enter: assert property (s_pick ##0 mode_q == swb_pkg::MD_DATA // [R10]
    && hold_q == swb_pkg::CODE_CMD |=> mode_q == swb_pkg::MD_CHECK && !req_q)
    else $error("switch code did not enter check mode");

  a_check_dup: assert property (s_dup |=> req_q && dat_q == swb_pkg::CODE_CMD // [R11]
    && mode_q == swb_pkg::MD_DATA)
    else $error("doubled code not written once");

  a_check_cmd: assert property (s_pick ##0 mode_q == swb_pkg::MD_CHECK // [R12]
    && hold_q != swb_pkg::CODE_CMD |=> mode_q == swb_pkg::MD_CMD)
    else $error("check mode did not fall to command mode");

  a_pres_rep: assert property (ph_q == swb_pkg::PH_IDLE && !hold_v_q && pres_q // [R14]
    && !mr |=> ph_q == swb_pkg::PH_SEND && rsp_q[1:0] == PRES_LSB)
    else $error("presence not reported");

  a_no_pres: assert property (mode_q == swb_pkg::MD_DATA |-> !pres_q) // [R15]
    else $error("presence pending in data mode");

  a_search_mute: assert property (s_pick ##0 mode_q == swb_pkg::MD_CMD // [R18]
    && hold_q[7:5] == 3'h5 && hold_q[0] |=> !req_q && ph_q == swb_pkg::PH_IDLE
    ##1 !txv_q)
    else $error("search control answered");

  a_speed_latch: assert property (s_pick ##0 mode_q == swb_pkg::MD_CMD // [R21]
    && hold_q[7] && hold_q[0] && hold_q[6:5] != swb_pkg::FN_PULSE
    && hold_q != swb_pkg::CODE_CMD |=> spd_q == $past(hold_q[3:2]))
    else $error("speed bits not latched");

  a_term_abort: assert property (ph_q == swb_pkg::PH_BUS && !bus_done_i && hold_v_q // [R19]
    && hold_q == swb_pkg::CODE_TERM && op_q == swb_pkg::OP_PULSE && !mr
    |=> bus_abort_o ##1 !bus_abort_o)
    else $error("terminate code did not abort pulse");

  a_rst_rsp: assert property (ph_q == swb_pkg::PH_BUS && bus_done_i // [R22]
    && op_q == swb_pkg::OP_RESET && !mr |=> rsp_q[4:2] == REV
    && rsp_q[5] == $past(vpp_i) && rsp_q[1:0] == $past(bus_result_i[1:0]))
    else $error("reset answer malformed");

  a_in_order: assert property (ph_q == swb_pkg::PH_BUS && !bus_done_i // [R23]
    |=> !req_q && !txv_q)
    else $error("new work started before bus completed");

endmodule // swb_mode_engine

/* File: sim/swb_host_uart.sv */
// Host serial port model: sends and receives 8-bit frames, LSB first.
// Assumes the engine's fixed bit rate derived from the package timing.
`timescale 1ns/1ps
module swb_host_uart #(
  parameter int TICK_DIV = swb_pkg::TICK_DIV
) (
  // Clock
  input  wire logic       clk_i,
  // Serial lines
  input  wire logic       line_i,
  output logic            line_o,
  // Received byte
  output logic [7:0]      rx_byte_o,
  output logic            rx_valid_o
);
  localparam int BIT_CLK = TICK_DIV * swb_pkg::OVS;
  logic [10:0] frm;
  initial begin
    line_o = 1'b1;
    rx_byte_o = 8'h00;
    rx_valid_o = 1'b0;
  end
  // A low stop level is the host's way to force a master reset
  task automatic send(input logic [7:0] b, input logic stop_hi, input int nstop);
    frm = {1'b1, stop_hi, b, 1'b0};
    for (int i = 0; i < 9 + nstop; i++) begin
      @(posedge clk_i) line_o <= frm[i];
      repeat (BIT_CLK - 1) @(posedge clk_i);
    end
    @(posedge clk_i) line_o <= 1'b1;
  endtask
  // Sample at mid bit; a frame without a high stop bit is dropped
  always begin
    @(negedge line_i);
    repeat (BIT_CLK / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLK) @(posedge clk_i);
      rx_byte_o[i] = line_i;
    end
    repeat (BIT_CLK) @(posedge clk_i);
    rx_valid_o <= line_i;
    @(posedge clk_i) rx_valid_o <= 1'b0;
  end
endmodule // swb_host_uart

/* File: sim/tb_top.sv */
// Self-checking bench for the mode engine with a host port model.
// Assumes a slot engine answer after a fixed delay, or on abort for pulses.
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic ser_rx, ser_tx, rx_valid, bus_req_o, bus_abort_o, bus_accel_o, bus_spu_arm_o;
  logic [7:0] rx_byte, reg_rdata_o, bus_data_o;
  logic [1:0] bus_speed_o;
  swb_pkg::swb_op_t bus_op_o;
  logic [1:0] reg_addr_i = 2'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic bus_done_i = 1'b0;
  logic [7:0] bus_result_i = 8'h00;
  logic bus_presence_i = 1'b0;
  logic vpp_i = 1'b1;
  swb_pkg::swb_op_t exp_op;
  logic [7:0] exp_data, res;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic hold = 1'b0;
  int nreq = 0;
  int nabort = 0;
  int compares = 0;
  int miscompares = 0;
  // Short tick keeps every frame brief; both ends share it
  localparam int TB_TICK = 4;

  always #2.5 clk_i = ~clk_i;

  swb_mode_engine #(.TICK_DIV(TB_TICK)) u_swb_mode_engine (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .ser_rx_i(ser_rx), .ser_tx_o(ser_tx),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .bus_req_o(bus_req_o),
    .bus_op_o(bus_op_o), .bus_data_o(bus_data_o), .bus_speed_o(bus_speed_o),
    .bus_accel_o(bus_accel_o), .bus_spu_arm_o(bus_spu_arm_o), .bus_abort_o(bus_abort_o),
    .bus_done_i(bus_done_i), .bus_result_i(bus_result_i),
    .bus_presence_i(bus_presence_i), .vpp_i(vpp_i));

  swb_host_uart #(.TICK_DIV(TB_TICK)) u_swb_host_uart (.clk_i(clk_i), .line_i(ser_tx),
    .line_o(ser_rx),
    .rx_byte_o(rx_byte), .rx_valid_o(rx_valid));

  task automatic chk(input logic [15:0] ex, input logic [15:0] g);
    compares++;
    if (g !== ex) begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, ex, g);
    end
  endtask

  task automatic close_out();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic reg_rd(input logic [1:0] a, input logic [7:0] ex);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 chk({8'h00, ex}, {8'h00, reg_rdata_o});
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask

  // Only one pending answer at a time keeps the order check simple
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    if (exp_q.size() != 0) begin
      chk(16'h0000, 16'(exp_q.size()));
      close_out();
    end
    repeat (2000) @(posedge clk_i);
  endtask

  task automatic pres_pulse();
    @(posedge clk_i) bus_presence_i <= 1'b1;
    @(posedge clk_i) bus_presence_i <= 1'b0;
    repeat (2000) @(posedge clk_i);
  endtask

  // Every answer byte is matched against the oldest note, under its mask
  always @(posedge clk_i) begin
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(16'h0100, {8'h00, rx_byte});
      end else begin
        e = exp_q.pop_front();
        chk({8'h00, e[7:0]}, {8'h00, rx_byte & e[15:8]});
      end
    end
  end

  // Slot engine stand-in; a pulse runs until the engine aborts it
  always @(posedge clk_i) begin
    if (bus_req_o === 1'b1) begin
      nreq++;
      chk({6'h00, exp_op, exp_data}, {6'h00, bus_op_o, bus_data_o});
      for (int k = 0; k < 5000 && hold; k++) begin
        @(posedge clk_i);
        if (bus_abort_o === 1'b1) begin
          hold = 1'b0;
          nabort++;
        end
      end
      chk(16'h0000, {15'h0000, hold});
      hold = 1'b0;
      repeat (20) @(posedge clk_i);
      bus_result_i <= res;
      bus_done_i <= 1'b1;
      @(posedge clk_i) bus_done_i <= 1'b0;
    end
  end

  initial begin
    logic [7:0] d;
    void'($urandom(32'h3e4c));
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    reg_rd(2'h0, 8'h00);
    reg_rd(2'h1, 8'h01);
    reg_rd(2'h3, 8'h00);
    u_swb_host_uart.send(8'hc1, 1'b1, 2);
    drain();
    chk(16'h0000, 16'(nreq));
    reg_rd(2'h0, 8'h04);
    exp_op = swb_pkg::OP_RESET;
    exp_data = 8'hc5;
    res = 8'h01;
    exp_q.push_back({8'hff, 2'b11, vpp_i, swb_pkg::REV_DEF, 2'b01});
    u_swb_host_uart.send(8'hc5, 1'b1, 1);
    drain();
    reg_rd(2'h0, 8'h0c);
    u_swb_host_uart.send(8'hb9, 1'b1, 1);
    drain();
    chk(16'h0006, {13'h0000, bus_accel_o, bus_speed_o});
    u_swb_host_uart.send(swb_pkg::CODE_DATA, 1'b1, 1);
    drain();
    reg_rd(2'h0, 8'h35);
    d = 8'($urandom);
    d = (d == swb_pkg::CODE_CMD) ? 8'h00 : d;
    exp_op = swb_pkg::OP_DATA;
    exp_data = d;
    res = 8'($urandom);
    exp_q.push_back({8'hff, res});
    u_swb_host_uart.send(d, 1'b1, 1);
    drain();
    chk(16'h0001, {15'h0000, bus_accel_o});
    pres_pulse();
    u_swb_host_uart.send(swb_pkg::CODE_CMD, 1'b1, 1);
    drain();
    reg_rd(2'h0, 8'h36);
    exp_data = swb_pkg::CODE_CMD;
    res = 8'($urandom);
    exp_q.push_back({8'hff, res});
    u_swb_host_uart.send(swb_pkg::CODE_CMD, 1'b1, 1);
    drain();
    reg_rd(2'h0, 8'h35);
    u_swb_host_uart.send(swb_pkg::CODE_CMD, 1'b1, 1);
    drain();
    exp_op = swb_pkg::OP_RESET;
    exp_data = 8'hc1;
    res = 8'h02;
    exp_q.push_back({8'hff, 2'b11, vpp_i, swb_pkg::REV_DEF, 2'b10});
    u_swb_host_uart.send(8'hc1, 1'b1, 1);
    drain();
    reg_rd(2'h0, 8'h24);
    exp_q.push_back(16'h0301);
    pres_pulse();
    drain();
    exp_q.push_back(16'hff16);
    u_swb_host_uart.send(8'h17, 1'b1, 1);
    drain();
    exp_q.push_back(16'hff16);
    u_swb_host_uart.send(8'h03, 1'b1, 1);
    drain();
    u_swb_host_uart.send(8'hc0, 1'b1, 1);
    drain();
    exp_op = swb_pkg::OP_PULSE;
    exp_data = 8'hef;
    hold = 1'b1;
    exp_q.push_back(16'hfcec);
    u_swb_host_uart.send(8'hef, 1'b1, 1);
    u_swb_host_uart.send(swb_pkg::CODE_TERM, 1'b1, 1);
    drain();
    chk(16'h0001, 16'(nabort));
    chk(16'h0001, {15'h0000, bus_spu_arm_o});
    u_swb_host_uart.send(8'h00, 1'b0, 2);
    repeat (2000) @(posedge clk_i);
    reg_rd(2'h0, 8'h00);
    d = 8'(nreq);
    u_swb_host_uart.send(8'hc1, 1'b1, 2);
    drain();
    chk({8'h00, d}, 16'(nreq));
    reg_rd(2'h0, 8'h04);
    reg_wr(2'h1, 8'h03);
    reg_rd(2'h0, 8'h00);
    reg_rd(2'h1, 8'h01);
    close_out();
  end
endmodule // tb_top
